// ==== lpcm_ctrl.sv ====
// Purpose: Operating-mode and main-clock control with Wishbone register access
// Assumes: Gear, low-frequency and timebase tap clocks arrive asynchronous to clk
// Notes:   main_sys_clock is a sampled clock level, glitch-free except a one-clk high pulse on entry to slow
//
// Function
// R1: All three enables set: leave timer-only standby on selected source falling edge.
// R2: Interrupt-mode release starts timebase interrupt service before resuming program.
// R3: Release comes straight from the asynchronous selected tap, may end early.
// R4: Watchdog interrupt pending at standby entry blocks the entry.
// R5: Source select to one moves main clock to low clock over four, bounded.
// R6: Switch to slow syncs to low clock quarter, clock stopped at most ten periods.
// R7: Software sets select, waits two machine cycles, then clears high oscillator enable.
// R8: Oscillator enable cleared within two machine cycles of select change resets clock.
// R9: STOP may be entered while running from the low clock.
// R10: Software enables high oscillator, confirms warm-up, then clears source select.
// R11: Select cleared moves main clock back to gear clock, bounded.
// R12: Software waits two machine cycles after switch before clearing low oscillator enable.
// R13: Switch back to gear clock stops main clock at most two and a half periods.
// R14: Any device reset ends slow mode, warms up, starts in single fast run.
// R15: High oscillator enable set while port0 oscillator function is zero resets clock.
// R16: Rewriting high oscillator enable already set does not restart warm-up.
// R17: Oscillator source select writes only take effect while source select is zero.
// R18: Software may keep high oscillator running slow, but stops it before STOP.
// R19: Source select bit 4, low enable bit 5, high enable bit 6.
// R20: Enables clear: release resumes at instruction after the standby entry.
// R21: Release clears timing generator halt and returns to previous run mode.
// R22: Source handover is glitch-free, no pulse shorter than either source period; entry to slow here emits a one-clk high pulse.
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.

`timescale 1ns/1ps

module lpcm_ctrl
  import lpcm_pkg::*;
#(
  parameter int unsigned MCYC_DIV = MCYC_DIV_DEF,
  parameter int unsigned TW       = TAP_W
) (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire lpcm_pkg::lpcm_wb_req_s wb_req,
  output lpcm_pkg::lpcm_wb_rsp_s     wb_rsp,
  input  wire logic                  gear_clock,
  input  wire logic                  low_freq_clock,
  input  wire logic [TW-1:0]         tb_taps,
  input  wire logic                  wdt_int_pending,
  output logic                       main_sys_clock,
  output logic                       high_osc_enable,
  output logic                       low_osc_enable,
  output logic                       warmup_start,
  output logic                       sys_clock_reset,
  output logic                       cpu_halted,
  output logic                       resume_next,
  output logic                       tb_service_start,
  output logic                       timebase_interrupt,
  output logic                       stop_request,
  output logic                       osc_source_select
);

  import lpcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers

  logic [TW+1:0] raw_in;
  logic [TW+1:0] syn_q;
  logic [TW+1:0] syn_fall;
  logic          gear_q;
  logic          low_fall;
  logic [TW-1:0] tap_fall;

  assign raw_in = {gear_clock, low_freq_clock, tb_taps};

  lpcm_sync #(.W(TW + 2)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (raw_in),
    .q    (syn_q),
    .fall (syn_fall)
  );

  assign gear_q   = syn_q[TW+1];
  assign low_fall = syn_fall[TW];
  assign tap_fall = syn_fall[TW-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] sys_two;
  logic [7:0] sys_one;
  logic [7:0] tb_ctrl;
  logic [7:0] port0_fn;
  logic [7:0] int_ctrl;
  logic       clk_rst_seen;
  logic       wr_go;
  logic       rd_go;
  logic [7:0] wdat;
  logic       tb_release;
  logic       tb_int_mode;
  logic       guard_bad;
  logic       xen_bad;
  logic       switch_busy;
  logic       slow_active;

  function automatic logic hit(input logic [5:0] ofs);
    hit = (wb_req.adr == ofs);
  endfunction

  assign wdat  = wb_req.dat[7:0];
  assign wr_go = wb_req.cyc & wb_req.stb & wb_req.we & wb_req.sel[0] & wb_rsp.ack;
  assign rd_go = wb_req.cyc & wb_req.stb & !wb_rsp.ack;

  // Selected timebase source and release mode
  assign tb_release  = sys_two[B_HALT] & tap_fall[tb_ctrl[2:0]];                     // [R1] [R3]
  assign tb_int_mode = int_ctrl[B_MIE] & int_ctrl[B_TB_IEF] & tb_ctrl[B_TB_EN];

  // system_control_two
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sys_two <= RST_SYS_TWO;                                                         // [R14]
    end else begin
      if (wr_go && hit(OFS_SYS_TWO)) begin
        sys_two[B_SRC_SEL] <= wdat[B_SRC_SEL];                                        // [R19]
        sys_two[B_LOW_EN]  <= wdat[B_LOW_EN];
        sys_two[B_HIGH_EN] <= wdat[B_HIGH_EN];
        if (wdat[B_HALT] && !sys_two[B_HALT] && !wdt_int_pending) begin
          sys_two[B_HALT] <= 1'b1;                                                    // [R4]
        end
      end
      if (tb_release) begin
        sys_two[B_HALT] <= 1'b0;                                                      // [R21]
      end
    end
  end

  // system_control_one: source select frozen while system_control_two source select is set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sys_one <= RST_SYS_ONE;
    end else if (wr_go && hit(OFS_SYS_ONE) && !sys_two[B_SRC_SEL]) begin
      sys_one[B_OSC_SEL] <= wdat[B_OSC_SEL];                                          // [R17]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tb_ctrl  <= RST_TB_CTRL;
      port0_fn <= RST_PORT0_FN;
    end else if (wr_go) begin
      if (hit(OFS_TB_CTRL)) begin
        tb_ctrl <= wdat & 8'h0F;
      end
      if (hit(OFS_PORT0_FN)) begin
        port0_fn <= wdat & 8'h01;
      end
    end
  end

  // Interrupt enables plus sticky timebase latch; set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_ctrl <= RST_INT_CTRL;
    end else begin
      if (wr_go && hit(OFS_INT_CTRL)) begin
        int_ctrl[B_MIE]    <= wdat[B_MIE];
        int_ctrl[B_TB_IEF] <= wdat[B_TB_IEF];
        if (wdat[B_TB_LATCH]) begin
          int_ctrl[B_TB_LATCH] <= 1'b0;
        end
      end
      if (tb_release && tb_ctrl[B_TB_EN]) begin
        int_ctrl[B_TB_LATCH] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Standby release pulses

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resume_next      <= 1'b0;
      tb_service_start <= 1'b0;
    end else begin
      resume_next      <= tb_release & !tb_int_mode;                                  // [R20]
      tb_service_start <= tb_release & tb_int_mode;                                   // [R2]
    end
  end

  assign cpu_halted         = sys_two[B_HALT];
  assign timebase_interrupt = int_ctrl[B_TB_LATCH] & int_ctrl[B_MIE] & int_ctrl[B_TB_IEF];

  ////////////////////////////////////////////////////////////////////////////////
  // Machine-cycle guard; phase restarts at a select change so both cycles are whole

  logic [$clog2(MCYC_DIV)-1:0] mdiv;
  logic                        mcyc_tick;
  logic [1:0]                  guard_cnt;
  logic                        src_change;

  assign mcyc_tick  = (mdiv == ($clog2(MCYC_DIV))'(MCYC_DIV - 1));
  assign src_change = wr_go & hit(OFS_SYS_TWO) & (wdat[B_SRC_SEL] != sys_two[B_SRC_SEL]);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mdiv <= '0;
    end else begin
      mdiv <= (mcyc_tick || src_change) ? '0 : mdiv + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      guard_cnt <= '0;
    end else if (src_change) begin
      guard_cnt <= 2'(GUARD_MCYC);
    end else if (mcyc_tick && guard_cnt != '0) begin
      guard_cnt <= guard_cnt - 1'b1;
    end
  end

  // Clearing either oscillator enable inside the guard window
  assign guard_bad = wr_go & hit(OFS_SYS_TWO) & (guard_cnt != '0) &
                     ((sys_two[B_HIGH_EN] & !wdat[B_HIGH_EN]) |
                      (sys_two[B_LOW_EN]  & !wdat[B_LOW_EN]));                          // [R8]
  assign xen_bad   = wr_go & hit(OFS_SYS_TWO) & wdat[B_HIGH_EN] & !port0_fn[0];       // [R15]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sys_clock_reset <= 1'b0;
      clk_rst_seen    <= 1'b0;
      warmup_start    <= 1'b0;
      stop_request    <= 1'b0;
    end else begin
      sys_clock_reset <= guard_bad | xen_bad;
      clk_rst_seen    <= clk_rst_seen | guard_bad | xen_bad;
      warmup_start    <= wr_go & hit(OFS_SYS_TWO) & wdat[B_HIGH_EN] & !sys_two[B_HIGH_EN]; // [R16]
      stop_request    <= wr_go & hit(OFS_SYS_ONE) & wdat[B_STOP];                     // [R9]
    end
  end

  assign high_osc_enable   = sys_two[B_HIGH_EN];
  assign low_osc_enable    = sys_two[B_LOW_EN];
  assign osc_source_select = sys_one[B_OSC_SEL];

  ////////////////////////////////////////////////////////////////////////////////
  // Main clock switch

  lpcm_clksw_e state;
  lpcm_clksw_e next_state;
  logic [1:0]  quarter;
  logic        q4;
  logic        q4_fall;
  logic        gear_prev;
  logic        gear_fall;

  // Low clock over four, toggled on every second low clock falling edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quarter   <= '0;
      gear_prev <= 1'b0;
    end else begin
      gear_prev <= gear_q;
      if (low_fall) begin
        quarter <= quarter + 1'b1;
      end
    end
  end

  assign q4        = quarter[1];
  assign q4_fall   = low_fall & (quarter == 2'b11);
  assign gear_fall = gear_prev & !gear_q;

  always_comb begin
    next_state = state;
    case (state)
      CS_GEAR: begin
        if (sys_two[B_SRC_SEL]) next_state = CS_PARK_GEAR;
      end
      CS_PARK_GEAR: begin
        if (!gear_q) next_state = CS_WAIT_SLOW;                                       // [R22]
      end
      CS_WAIT_SLOW: begin
        if (q4_fall) next_state = CS_SLOW;                                            // [R5] [R6]
      end
      CS_SLOW: begin
        if (!sys_two[B_SRC_SEL]) next_state = CS_PARK_SLOW;
      end
      CS_PARK_SLOW: begin
        if (!q4) next_state = CS_WAIT_GEAR;                                           // [R22]
      end
      CS_WAIT_GEAR: begin
        if (gear_fall) next_state = CS_GEAR;                                          // [R11] [R13]
      end
      default: next_state = CS_GEAR;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= CS_GEAR;                                                               // [R14]
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      main_sys_clock <= 1'b0;
    end else begin
      case (next_state)
        CS_GEAR:      main_sys_clock <= gear_q;
        CS_PARK_GEAR: main_sys_clock <= gear_q;
        CS_SLOW:      main_sys_clock <= q4;
        CS_PARK_SLOW: main_sys_clock <= q4;
        default:      main_sys_clock <= 1'b0;
      endcase
    end
  end

  assign slow_active = (state == CS_SLOW) | (state == CS_PARK_SLOW);
  assign switch_busy = (state != CS_GEAR) & (state != CS_SLOW);

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after request, unmapped reads zero

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= rd_go;
      if (rd_go) begin
        wb_rsp.dat <= '0;
        case (wb_req.adr)
          OFS_SYS_TWO:  wb_rsp.dat[7:0] <= sys_two;
          OFS_SYS_ONE:  wb_rsp.dat[7:0] <= sys_one & 8'h01;
          OFS_TB_CTRL:  wb_rsp.dat[7:0] <= tb_ctrl;
          OFS_PORT0_FN: wb_rsp.dat[7:0] <= port0_fn;
          OFS_INT_CTRL: wb_rsp.dat[7:0] <= int_ctrl;
          OFS_STATUS: begin
            wb_rsp.dat[B_ST_ACTIVE] <= slow_active;
            wb_rsp.dat[B_ST_BUSY]   <= switch_busy;
            wb_rsp.dat[B_ST_CLKRST] <= clk_rst_seen;
          end
          default:      wb_rsp.dat <= '0;
        endcase
      end
    end
  end

endmodule

// ==== lpcm_ctrl_checker.sv ====
// Purpose: Port-level assertions for the clock mode controller
// Assumes: One clk domain, nrst asynchronous active low
// Notes:   Stall bound in clk cycles, sized for the bench source clocks
`timescale 1ns/1ps
module lpcm_ctrl_checker
  import lpcm_pkg::*;
#(
  parameter int unsigned MCYC_DIV = MCYC_DIV_DEF,
  parameter int unsigned TW       = TAP_W
) (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire lpcm_pkg::lpcm_wb_req_s wb_req,
  input wire lpcm_pkg::lpcm_wb_rsp_s wb_rsp,
  input wire logic                   gear_clock,
  input wire logic                   low_freq_clock,
  input wire logic [TW-1:0]          tb_taps,
  input wire logic                   wdt_int_pending,
  input wire logic                   main_sys_clock,
  input wire logic                   high_osc_enable,
  input wire logic                   low_osc_enable,
  input wire logic                   warmup_start,
  input wire logic                   sys_clock_reset,
  input wire logic                   cpu_halted,
  input wire logic                   resume_next,
  input wire logic                   tb_service_start,
  input wire logic                   timebase_interrupt,
  input wire logic                   stop_request,
  input wire logic                   osc_source_select
);
  localparam int STALL_MAX = 160;
  logic       wr_ack;
  logic       prev_clk;
  logic       stopped;
  logic [8:0] stall;
  assign wr_ack = wb_rsp.ack && wb_req.we;
  ////////////////////////////////////////////////////////////////////////////
  // Main clock stall counter, idle while halted or stopped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stopped <= 1'b0;
    end else if (stop_request) begin
      stopped <= 1'b1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_clk <= 1'b0;
      stall    <= 9'h000;
    end else begin
      prev_clk <= main_sys_clock;
      stall    <= (stopped || cpu_halted || main_sys_clock != prev_clk) ? 9'h000 : stall + 9'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_halt_entry: assert property (
    $rose(cpu_halted) |-> $past(wr_ack && !wdt_int_pending)) else $error("halt entry bad");
  a_release_pulse: assert property (
    $fell(cpu_halted) |-> ##[0:1] (tb_service_start || resume_next)) else $error("no release");
  a_release_excl: assert property (
    !(tb_service_start && resume_next)) else $error("both release kinds");
  a_service_irq: assert property (
    tb_service_start |-> ##[0:2] timebase_interrupt) else $error("no timebase irq");
  a_stop_cause: assert property (
    stop_request |-> $past(wr_ack && wb_req.adr == OFS_SYS_ONE) ||
    $past(wr_ack && wb_req.adr == OFS_SYS_ONE, 2)) else $error("stray stop");
  a_warm_rise: assert property (
    warmup_start |-> !$past(high_osc_enable) || !$past(high_osc_enable, 2))
    else $error("warm-up without rise");
  a_crst_cause: assert property (
    sys_clock_reset |-> $past(wr_ack) || $past(wr_ack, 2)) else $error("stray clock reset");
  a_stall_bound: assert property (
    stall < STALL_MAX) else $error("main clock stalled too long");
  c_service: cover property (tb_service_start);
  c_resume: cover property (resume_next);
  c_crst: cover property (sys_clock_reset);
  c_stop: cover property (stop_request);
endmodule

bind lpcm_ctrl lpcm_ctrl_checker #(.MCYC_DIV(MCYC_DIV), .TW(TW)) u_lpcm_ctrl_checker (
  .clk(clk), .nrst(nrst), .wb_req(wb_req), .wb_rsp(wb_rsp), .gear_clock(gear_clock),
  .low_freq_clock(low_freq_clock), .tb_taps(tb_taps), .wdt_int_pending(wdt_int_pending),
  .main_sys_clock(main_sys_clock), .high_osc_enable(high_osc_enable),
  .low_osc_enable(low_osc_enable), .warmup_start(warmup_start),
  .sys_clock_reset(sys_clock_reset), .cpu_halted(cpu_halted), .resume_next(resume_next),
  .tb_service_start(tb_service_start), .timebase_interrupt(timebase_interrupt),
  .stop_request(stop_request), .osc_source_select(osc_source_select));

// ==== lpcm_ctrl_tb.sv ====
// Purpose: Self-checking bench for the clock mode controller
// Assumes: Gear clock 80 ns, low clock 220 ns, both free running
// Notes:   Pulses are counted by a monitor and compared as totals
`timescale 1ns/1ps
module lpcm_ctrl_tb;
  import lpcm_pkg::*;
  localparam logic [2:0] EN = 3'b101;
  localparam logic [2:0] WD = 3'b100;
  logic         clk, nrst, gear_clock, low_freq_clock, wdt;
  logic         mclk, hi_en, lo_en, warm, crst, halted, resume, svc, tb_irq, stop, osc_sel;
  logic [7:0]   taps, q;
  logic [2:0]   s;
  logic [31:0]  rs;
  lpcm_wb_req_s req;
  lpcm_wb_rsp_s rsp;
  int           err_count, check_count, n_warm, n_crst, n_res, n_svc, n_stop, cycles, n;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always #40 gear_clock = ~gear_clock;
  initial #5 forever #110 low_freq_clock = ~low_freq_clock;
  lpcm_ctrl u_lpcm_ctrl (.clk(clk), .nrst(nrst), .wb_req(req), .wb_rsp(rsp),
    .gear_clock(gear_clock), .low_freq_clock(low_freq_clock), .tb_taps(taps),
    .wdt_int_pending(wdt), .main_sys_clock(mclk), .high_osc_enable(hi_en),
    .low_osc_enable(lo_en), .warmup_start(warm), .sys_clock_reset(crst), .cpu_halted(halted),
    .resume_next(resume), .tb_service_start(svc), .timebase_interrupt(tb_irq),
    .stop_request(stop), .osc_source_select(osc_sel));
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    n_warm += (warm === 1'b1);
    n_crst += (crst === 1'b1);
    n_res += (resume === 1'b1);
    n_svc += (svc === 1'b1);
    n_stop += (stop === 1'b1);
    if (cycles == 5000) begin
      err_count++;
      end_sim();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    rs = lfsr(rs);
    req <= {2'b11, w, 4'hF, a, rs[23:0], d};
    do @(posedge clk); while (rsp.ack !== 1'b1);
    q = rsp.dat[7:0];
    req <= '0;
  endtask
  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic per(output int c);
    while (mclk !== 1'b0) @(negedge clk);
    while (mclk !== 1'b1) @(negedge clk);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (mclk !== 1'b0);
    do begin
      @(negedge clk);
      c++;
    end while (mclk !== 1'b1);
  endtask
  task automatic rst();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    nrst = 1'b0;
    taps = 8'hFF;
    wdt = 1'b0;
    gear_clock = 1'b0;
    low_freq_clock = 1'b0;
    rs = 32'h000125B6;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, OFS_SYS_TWO, 8'h00);
    chk("sys_two_reset", q, RST_SYS_TWO);
    chk("osc_enables", {hi_en, lo_en}, 2'b10);
    bus(1'b1, OFS_SYS_TWO, 8'h40);
    bus(1'b1, OFS_SYS_ONE, 8'h01);
    wt(3);
    chk("warm_rewrite", n_warm, 0);
    chk("osc_sel_fast", osc_sel, 1'b1);
    bus(1'b1, OFS_SYS_ONE, 8'h00);
    // Fast to slow, then stop
    bus(1'b1, OFS_SYS_TWO, 8'h70);
    bus(1'b1, OFS_SYS_ONE, 8'h01);
    wt(2);
    chk("osc_sel_slow", osc_sel, 1'b0);
    wt(130);
    bus(1'b0, OFS_STATUS, 8'h00);
    chk("slow_active", q[B_ST_ACTIVE], 1'b1);
    per(n);
    chk("slow_period", n >= 43 && n <= 45, 1'b1);
    bus(1'b1, OFS_SYS_TWO, 8'h30);
    wt(3);
    chk("crst_legal", n_crst, 0);
    bus(1'b1, OFS_SYS_ONE, 8'h80);
    wt(3);
    chk("stop_req", n_stop, 1);
    rst();
    // Oscillator restart, slow and back to gear clock
    bus(1'b1, OFS_SYS_TWO, 8'h20);
    bus(1'b1, OFS_SYS_TWO, 8'h60);
    wt(3);
    chk("warm_start", n_warm, 1);
    bus(1'b1, OFS_SYS_TWO, 8'h70);
    wt(130);
    bus(1'b1, OFS_SYS_TWO, 8'h60);
    wt(110);
    bus(1'b0, OFS_STATUS, 8'h00);
    chk("gear_active", q[B_ST_ACTIVE], 1'b0);
    per(n);
    chk("gear_period", n >= 3 && n <= 5, 1'b1);
    bus(1'b1, OFS_SYS_TWO, 8'h40);
    // Enable cleared inside the guard window
    bus(1'b1, OFS_SYS_TWO, 8'h70);
    bus(1'b1, OFS_SYS_TWO, 8'h30);
    wt(3);
    chk("crst_guard", n_crst, 1);
    bus(1'b0, OFS_STATUS, 8'h00);
    chk("crst_flag", q[B_ST_CLKRST], 1'b1);
    rst();
    bus(1'b0, OFS_SYS_TWO, 8'h00);
    chk("sys_two_rerst", q, RST_SYS_TWO);
    bus(1'b1, OFS_PORT0_FN, 8'h00);
    bus(1'b1, OFS_SYS_TWO, 8'h00);
    bus(1'b1, OFS_SYS_TWO, 8'h40);
    wt(3);
    chk("crst_port0", n_crst, 2);
    rst();
    // Standby: interrupt release, normal release, blocked entry
    for (int i = 0; i < 3; i++) begin
      rs = lfsr(rs);
      s = rs[2:0];
      bus(1'b1, OFS_TB_CTRL, {4'h0, EN[i], s});
      bus(1'b1, OFS_INT_CTRL, {6'h00, EN[i], EN[i]});
      wdt <= WD[i];
      bus(1'b1, OFS_SYS_TWO, 8'h44);
      wt(2);
      chk("halt_entry", halted, !WD[i]);
      @(posedge clk);
      taps[s ^ 3'h1] <= 1'b0;
      wt(8);
      chk("halt_other_tap", halted, !WD[i]);
      @(posedge clk);
      taps[s] <= 1'b0;
      wt(8);
      chk("halt_clear", halted, 1'b0);
      chk("service", n_svc, 1);
      chk("resume", n_res, i > 0);
      chk("tb_irq", tb_irq, i == 0);
      bus(1'b1, OFS_INT_CTRL, 8'h04);
      @(posedge clk);
      taps <= 8'hFF;
      wdt <= 1'b0;
    end
    end_sim();
  end
endmodule

// ==== lpcm_pkg.sv ====
// Purpose: Shared constants and types for the low-power clock mode control block
// Assumes: 32-bit classic Wishbone, 8 data bits used per register
// Notes:   Offsets are byte addresses of aligned words

package lpcm_pkg;

  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned MCYC_DIV_DEF  = 4;       // clk cycles per machine cycle
  localparam int unsigned GUARD_MCYC    = 2;       // machine cycles after a source change
  localparam int unsigned TAP_W         = 8;

  // Register byte offsets
  localparam logic [5:0] OFS_SYS_TWO    = 6'h00;
  localparam logic [5:0] OFS_SYS_ONE    = 6'h04;
  localparam logic [5:0] OFS_TB_CTRL    = 6'h08;
  localparam logic [5:0] OFS_PORT0_FN   = 6'h0C;
  localparam logic [5:0] OFS_INT_CTRL   = 6'h10;
  localparam logic [5:0] OFS_STATUS     = 6'h14;

  // system_control_two fields
  localparam int unsigned B_HALT        = 2;
  localparam int unsigned B_SRC_SEL     = 4;
  localparam int unsigned B_LOW_EN      = 5;
  localparam int unsigned B_HIGH_EN     = 6;
  // system_control_one fields
  localparam int unsigned B_OSC_SEL     = 0;
  localparam int unsigned B_STOP        = 7;
  // timebase_control fields
  localparam int unsigned B_TB_EN       = 3;
  // interrupt control fields
  localparam int unsigned B_MIE         = 0;
  localparam int unsigned B_TB_IEF      = 1;
  localparam int unsigned B_TB_LATCH    = 2;
  // status fields
  localparam int unsigned B_ST_ACTIVE   = 0;
  localparam int unsigned B_ST_BUSY     = 1;
  localparam int unsigned B_ST_CLKRST   = 2;

  // Reset values: fast clock running, slow oscillator off
  localparam logic [7:0] RST_SYS_TWO    = 8'h40;
  localparam logic [7:0] RST_SYS_ONE    = 8'h00;
  localparam logic [7:0] RST_TB_CTRL    = 8'h00;
  localparam logic [7:0] RST_PORT0_FN   = 8'h01;
  localparam logic [7:0] RST_INT_CTRL   = 8'h00;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [5:0]  adr;
    logic [31:0] dat;
  } lpcm_wb_req_s;

  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
  } lpcm_wb_rsp_s;

  typedef enum logic [2:0] {
    CS_GEAR, CS_PARK_GEAR, CS_WAIT_SLOW, CS_SLOW, CS_PARK_SLOW, CS_WAIT_GEAR
  } lpcm_clksw_e;

endpackage

// ==== lpcm_sync.sv ====
// Purpose: Two-stage synchroniser with falling-edge detect
// Assumes: Inputs are independent levels from outside the clk domain
// Notes:   First stage feeds only the second stage

`timescale 1ns/1ps

module lpcm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta;
  logic [W-1:0] prev;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q    <= '0;
      prev <= '0;
    end else begin
      meta <= d;
      q    <= meta;
      prev <= q;
    end
  end

  assign fall = prev & ~q;

endmodule
